/* logic/general_purpose_timer_pair.sv */
`timescale 1ns/1ps
module general_purpose_timer_pair #(
  parameter int DATA_W = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [4:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_W-1:0] reg_rdata,
  // timer pins, slot 1 is core_count_pin and core_direction_pin
  input wire logic [timer_pair_pkg::NUM_TIMERS-1:0] timer_input_pin,
  input wire logic [timer_pair_pkg::NUM_TIMERS-1:0] external_direction_pin,
  input wire logic capture_pin,
  // outputs
  output logic toggle_output_pin,
  output logic capture_compare_clock,
  output logic [timer_pair_pkg::NUM_EVENTS-1:0] event_pulse,
  output logic irq
);
  import timer_pair_pkg::*;

  logic [DATA_W-1:0] ctrl_q [NUM_TIMERS];
  logic [DATA_W-1:0] cnt_q [NUM_TIMERS];
  logic [DATA_W-1:0] capreg_q;
  logic [5:0] capctrl_q;
  logic [NUM_EVENTS-1:0] status_q;
  logic [NUM_EVENTS-1:0] status_d;
  logic [NUM_EVENTS-1:0] mask_q;
  logic [NUM_EVENTS-1:0] events;
  logic [NUM_EVENTS-1:0] pulse_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rd_mux;
  logic [4:0] base_cnt_q [2];
  logic [7:0] pre_cnt_q [2];
  logic [1:0] base_tick;
  logic [1:0] tgl_q;
  logic [1:0] shadow_q;
  logic toggle_out_q;
  logic cc_clock_q;
  logic irq_q;
  logic [5:0] lvl_a;
  logic [5:0] rise_a;
  logic [5:0] fall_a;
  logic [4:0] lvl_b;
  logic [4:0] rise_b;
  logic [4:0] fall_b;
  logic [NUM_TIMERS-1:0] in_lvl;
  logic [NUM_TIMERS-1:0] in_rise;
  logic [NUM_TIMERS-1:0] in_fall;
  logic [NUM_TIMERS-1:0] dir_lvl;
  logic [NUM_TIMERS-1:0] pre_tick;
  logic [NUM_TIMERS-1:0] dir_down;
  logic [NUM_TIMERS-1:0] count_ev;
  logic [NUM_TIMERS-1:0] trig_ev;
  logic [NUM_TIMERS-1:0] ouf;
  logic [NUM_TIMERS-1:0] cnt_wr;
  logic [NUM_TIMERS-1:0] ctrl_wr;
  logic reload_a;
  logic reload_b;
  logic cap_rise;
  logic cap_fall;
  logic cap_ev;

  // each block samples its pins with its own basic clock
  input_sampler #(.WIDTH(6)) u_first_sampler (
    .clock(clock),
    .rst_n(rst_n),
    .sample(base_tick[0]),
    .pin_in({external_direction_pin[2:0], timer_input_pin[2:0]}),
    .level(lvl_a),
    .rise(rise_a),
    .fall(fall_a)
  );

  input_sampler #(.WIDTH(5)) u_second_sampler (
    .clock(clock),
    .rst_n(rst_n),
    .sample(base_tick[1]),
    .pin_in({capture_pin, external_direction_pin[4:3], timer_input_pin[4:3]}),
    .level(lvl_b),
    .rise(rise_b),
    .fall(fall_b)
  );

  assign in_lvl = {lvl_b[1:0], lvl_a[2:0]};
  assign in_rise = {rise_b[1:0], rise_a[2:0]};
  assign in_fall = {fall_b[1:0], fall_a[2:0]};
  assign dir_lvl = {lvl_b[3:2], lvl_a[5:3]};

  // core of block b sits in slot 3*b+1
  // a count past the new last value ends the phase at once, no long wrap
  always_comb begin
    base_tick[0] = base_cnt_q[0] >= base_last(ctrl_q[FIRST_CORE][F_BPS+:2]);
    base_tick[1] = base_cnt_q[1] >= base_last(ctrl_q[SECOND_CORE][F_BPS+:2]);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int b = 0; b < 2; b++) begin
        base_cnt_q[b] <= 5'h00;
        pre_cnt_q[b] <= 8'h00;
      end
    end else begin
      for (int b = 0; b < 2; b++) begin
        base_cnt_q[b] <= base_tick[b] ? 5'h00 : base_cnt_q[b] + 5'h01;
        if (base_tick[b]) begin
          pre_cnt_q[b] <= pre_cnt_q[b] + 8'h01;
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_TIMERS; i++) begin
      cnt_wr[i] = reg_write && (reg_addr == 5'(RA_CNT0 + i));
      ctrl_wr[i] = reg_write && (reg_addr == 5'(RA_CTRL0 + i));
    end
  end

  always_comb begin
    logic [2:0] sel;
    logic [2:0] mode;
    logic blk;
    logic run;
    logic pin_hit;
    logic tl_hit;
    sel = 3'h0;
    mode = 3'h0;
    blk = 1'b0;
    run = 1'b0;
    pin_hit = 1'b0;
    tl_hit = 1'b0;
    for (int i = 0; i < NUM_TIMERS; i++) begin
      sel = ctrl_q[i][F_SEL+:3];
      mode = ctrl_q[i][F_MODE+:3];
      run = ctrl_q[i][F_RUN];
      blk = (i >= SECOND_AUX);
      pre_tick[i] = base_tick[blk] && ((pre_cnt_q[blk] & pre_mask(sel)) == pre_mask(sel));
      dir_down[i] = ctrl_q[i][F_EXTDIR] ? (dir_lvl[i] ^ ctrl_q[i][F_DIR]) : ctrl_q[i][F_DIR];
      pin_hit = !sel[2] && edge_hit(sel[1:0], in_rise[i], in_fall[i]);
      // aux slots only; latch edges come from latch against its shadow
      tl_hit = sel[2] && (i != FIRST_CORE) && (i != SECOND_CORE)
        && edge_hit(sel[1:0], tgl_q[blk] & ~shadow_q[blk], ~tgl_q[blk] & shadow_q[blk]);
      count_ev[i] = 1'b0;
      trig_ev[i] = 1'b0;
      case (mode)
        M_TIMER: count_ev[i] = run && pre_tick[i];
        M_GATED_LO, M_GATED_HI: count_ev[i] = run && pre_tick[i] && (in_lvl[i] == mode[0]);
        M_COUNTER: count_ev[i] = run && (pin_hit || tl_hit);
        M_RELOAD: trig_ev[i] = (i == FIRST_AUX_A || i == FIRST_AUX_B) && (pin_hit || tl_hit);
        M_CAPTURE: trig_ev[i] = (i == FIRST_AUX_A || i == FIRST_AUX_B) && pin_hit;
        M_INCR: begin
          if (i == FIRST_CORE && !sel[2]) begin
            count_ev[i] = run && ((sel[0] && (in_rise[i] || in_fall[i]))
              || (sel[1] && (rise_a[4] || fall_a[4])));
          end
        end
        default: ;
      endcase
      ouf[i] = count_ev[i] && (dir_down[i] ? (cnt_q[i] == '0) : (cnt_q[i] == '1));
    end
  end

  // both aux on the same trigger: the second aux wins
  assign reload_a = trig_ev[FIRST_AUX_A] && (ctrl_q[FIRST_AUX_A][F_MODE+:3] == M_RELOAD);
  assign reload_b = trig_ev[FIRST_AUX_B] && (ctrl_q[FIRST_AUX_B][F_MODE+:3] == M_RELOAD);

  always_comb begin
    cap_rise = 1'b0;
    cap_fall = 1'b0;
    case (capctrl_q[C_SRC+:2])
      CS_PIN: begin
        cap_rise = rise_b[4];
        cap_fall = fall_b[4];
      end
      CS_CORE_COUNT: begin
        cap_rise = in_rise[FIRST_CORE];
        cap_fall = in_fall[FIRST_CORE];
      end
      CS_CORE_DIR: begin
        cap_rise = rise_a[4];
        cap_fall = fall_a[4];
      end
      default: ;
    endcase
    cap_ev = edge_hit(capctrl_q[C_EDGE+:2], cap_rise, cap_fall);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        cnt_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (cnt_wr[i]) begin
          cnt_q[i] <= reg_wdata;
        end else if (i == FIRST_CORE && (reload_a || reload_b)) begin
          cnt_q[i] <= reload_b ? cnt_q[FIRST_AUX_B] : cnt_q[FIRST_AUX_A];
        end else if (i == SECOND_CORE && ouf[i] && capctrl_q[C_RLD]) begin
          cnt_q[i] <= capreg_q;
        end else if (i == SECOND_AUX && cap_ev && capctrl_q[C_MULT]) begin
          cnt_q[i] <= '0;
        end else if (trig_ev[i] && ctrl_q[i][F_MODE+:3] == M_CAPTURE) begin
          cnt_q[i] <= cnt_q[FIRST_CORE];
        end else if (count_ev[i]) begin
          cnt_q[i] <= dir_down[i] ? cnt_q[i] - DATA_W'(1) : cnt_q[i] + DATA_W'(1);
        end
      end
    end
  end

  // a software write moves latch and shadow together, so no edge is seen
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tgl_q <= 2'h0;
      shadow_q <= 2'h0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        if (ctrl_wr[3 * b + 1]) begin
          tgl_q[b] <= reg_wdata[F_TGL];
          shadow_q[b] <= reg_wdata[F_TGL];
        end else begin
          if (ouf[3 * b + 1]) begin
            tgl_q[b] <= ~tgl_q[b];
          end
          shadow_q[b] <= tgl_q[b];
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        ctrl_q[i] <= DATA_W'(CTRL_RESET);
      end
    end else begin
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (ctrl_wr[i]) begin
          ctrl_q[i] <= reg_wdata;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      capreg_q <= '0;
      capctrl_q <= CAPCTRL_RESET;
    end else begin
      if (reg_write && reg_addr == RA_CAPREG) begin
        capreg_q <= reg_wdata;
      end else if (cap_ev) begin
        capreg_q <= cnt_q[SECOND_AUX];
      end
      if (reg_write && reg_addr == RA_CAPCTRL) begin
        capctrl_q <= reg_wdata[5:0];
      end
    end
  end

  // a new event in the clearing read cycle survives the clear
  always_comb begin
    events = {cap_ev, ouf | trig_ev};
    status_d = events | ((reg_read && reg_addr == RA_STATUS) ? '0 : status_q);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= '0;
      mask_q <= '0;
      pulse_q <= '0;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      pulse_q <= events;
      irq_q <= |(status_d & mask_q);
      if (reg_write && reg_addr == RA_MASK) begin
        mask_q <= reg_wdata[NUM_EVENTS-1:0];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      toggle_out_q <= 1'b1;
      cc_clock_q <= 1'b0;
    end else begin
      toggle_out_q <= ctrl_q[SECOND_CORE][F_TOE] ? tgl_q[1] : 1'b1;
      cc_clock_q <= ouf[SECOND_CORE];
    end
  end

  always_comb begin
    rd_mux = '0;
    for (int i = 0; i < NUM_TIMERS; i++) begin
      if (reg_addr == 5'(RA_CTRL0 + i)) begin
        rd_mux = ctrl_q[i];
        rd_mux[F_RDIR] = dir_down[i];
        rd_mux[F_TGL] = (i == FIRST_CORE || i == SECOND_CORE) ? tgl_q[i / 3] : 1'b0;
      end
      if (reg_addr == 5'(RA_CNT0 + i)) begin
        rd_mux = cnt_q[i];
      end
    end
    case (reg_addr)
      RA_CAPREG: rd_mux = capreg_q;
      RA_CAPCTRL: rd_mux = DATA_W'(capctrl_q);
      RA_STATUS: rd_mux = DATA_W'(status_q);
      RA_MASK: rd_mux = DATA_W'(mask_q);
      default: ;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= reg_read ? rd_mux : '0;
    end
  end

  assign reg_rdata = rdata_q;
  assign toggle_output_pin = toggle_out_q;
  assign capture_compare_clock = cc_clock_q;
  assign event_pulse = pulse_q;
  assign irq = irq_q;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_edge_two_samples: assert property (
    in_rise[FIRST_CORE] |-> in_lvl[FIRST_CORE] && !$past(in_lvl[FIRST_CORE])
  ) else $error("edge without two differing samples");

  a_count_up_step: assert property (
    count_ev[FIRST_CORE] && !dir_down[FIRST_CORE] && !ctrl_q[FIRST_CORE][F_EXTDIR]
      && !cnt_wr[FIRST_CORE] && !reload_a && !reload_b
      |=> cnt_q[FIRST_CORE] == $past(cnt_q[FIRST_CORE]) + DATA_W'(1)
  ) else $error("core did not count up by one");

  a_basic_period: assert property (
    disable iff (!rst_n || ctrl_wr[FIRST_CORE])
    base_tick[0] && ctrl_q[FIRST_CORE][F_BPS+:2] == 2'h0
      |=> (!base_tick[0]) [*7] ##1 base_tick[0]
  ) else $error("basic clock period wrong for default prescaler");

  a_counter_disabled: assert property (
    ctrl_q[FIRST_CORE][F_MODE+:3] == M_COUNTER && ctrl_q[FIRST_CORE][F_SEL+:3] == 3'h0
      && !cnt_wr[FIRST_CORE] && !reload_a && !reload_b
      |=> $stable(cnt_q[FIRST_CORE])
  ) else $error("disabled core counter changed");

  a_aux_capture: assert property (
    trig_ev[FIRST_AUX_A] && ctrl_q[FIRST_AUX_A][F_MODE+:3] == M_CAPTURE
      && !cnt_wr[FIRST_AUX_A]
      |=> cnt_q[FIRST_AUX_A] == $past(cnt_q[FIRST_CORE])
  ) else $error("aux did not capture core value");

  a_reload_priority: assert property (
    reload_b && !cnt_wr[FIRST_CORE] |=> cnt_q[FIRST_CORE] == $past(cnt_q[FIRST_AUX_B])
  ) else $error("core not reloaded from second aux");

  a_incr_stopped: assert property (
    ctrl_q[FIRST_CORE][F_MODE+:3] == M_INCR && ctrl_q[FIRST_CORE][F_SEL+:3] == 3'h0
      && !cnt_wr[FIRST_CORE] && !reload_a && !reload_b
      |=> $stable(cnt_q[FIRST_CORE])
  ) else $error("incremental mode counted while stopped");

  a_latch_toggle: assert property (
    ouf[SECOND_CORE] && !ctrl_wr[SECOND_CORE]
      |=> tgl_q[1] != $past(tgl_q[1]) ##1 (!capture_compare_clock || $past(ouf[SECOND_CORE]))
  ) else $error("second core latch did not toggle");

  a_capreg_reload: assert property (
    ouf[SECOND_CORE] && capctrl_q[C_RLD] && !cnt_wr[SECOND_CORE]
      |=> cnt_q[SECOND_CORE] == $past(capreg_q) && capture_compare_clock
  ) else $error("second core not reloaded from capture register");

  a_cpu_wins: assert property (
    cnt_wr[SECOND_CORE] |=> cnt_q[SECOND_CORE] == $past(reg_wdata)
  ) else $error("cpu write lost to hardware update");
endmodule : general_purpose_timer_pair

/* logic/timer_pair_pkg.sv */
package timer_pair_pkg;
  // timer slots
  localparam int NUM_TIMERS = 5;
  localparam int NUM_EVENTS = 6;
  localparam int FIRST_AUX_A = 0;
  localparam int FIRST_CORE = 1;
  localparam int FIRST_AUX_B = 2;
  localparam int SECOND_AUX = 3;
  localparam int SECOND_CORE = 4;
  // register offsets, one word each
  localparam logic [4:0] RA_CTRL0 = 5'h00;
  localparam logic [4:0] RA_CNT0 = 5'h08;
  localparam logic [4:0] RA_CAPREG = 5'h10;
  localparam logic [4:0] RA_CAPCTRL = 5'h11;
  localparam logic [4:0] RA_STATUS = 5'h12;
  localparam logic [4:0] RA_MASK = 5'h13;
  // control word fields
  localparam int F_SEL = 0;
  localparam int F_MODE = 3;
  localparam int F_RUN = 6;
  localparam int F_DIR = 7;
  localparam int F_EXTDIR = 8;
  localparam int F_RDIR = 9;
  localparam int F_TGL = 10;
  localparam int F_TOE = 11;
  localparam int F_BPS = 12;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // capture control fields
  localparam int C_SRC = 0;
  localparam int C_EDGE = 2;
  localparam int C_RLD = 4;
  localparam int C_MULT = 5;
  localparam logic [5:0] CAPCTRL_RESET = 6'h00;
  // timer modes
  localparam logic [2:0] M_TIMER = 3'h0;
  localparam logic [2:0] M_COUNTER = 3'h1;
  localparam logic [2:0] M_GATED_LO = 3'h2;
  localparam logic [2:0] M_GATED_HI = 3'h3;
  localparam logic [2:0] M_RELOAD = 3'h4;
  localparam logic [2:0] M_CAPTURE = 3'h5;
  localparam logic [2:0] M_INCR = 3'h6;
  // capture trigger sources
  localparam logic [1:0] CS_PIN = 2'h0;
  localparam logic [1:0] CS_CORE_COUNT = 2'h1;
  localparam logic [1:0] CS_CORE_DIR = 2'h2;

  // last count of the basic clock divider; the encoding is not linear
  function automatic logic [4:0] base_last(input logic [1:0] bps);
    case (bps)
      2'h1: base_last = 5'h03;
      2'h0: base_last = 5'h07;
      2'h3: base_last = 5'h0f;
      default: base_last = 5'h1f;
    endcase
  endfunction : base_last

  function automatic logic [7:0] pre_mask(input logic [2:0] sel);
    pre_mask = 8'((9'h001 << sel) - 9'h001);
  endfunction : pre_mask

  // 01 rising, 10 falling, 11 any, 00 none
  function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
    edge_hit = (sel[0] & rise) | (sel[1] & fall);
  endfunction : edge_hit
endpackage : timer_pair_pkg

/* logic/input_sampler.sv */
`timescale 1ns/1ps
module input_sampler #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // basic clock strobe and raw pins
  input wire logic sample,
  input wire logic [WIDTH-1:0] pin_in,
  // sampled level and one-cycle transition pulses
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] level_q;
  logic [WIDTH-1:0] rise_q;
  logic [WIDTH-1:0] fall_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  // a pin shorter than one basic phase may be missed entirely
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= '0;
      rise_q <= '0;
      fall_q <= '0;
    end else if (sample) begin
      level_q <= sync_q;
      rise_q <= sync_q & ~level_q;
      fall_q <= ~sync_q & level_q;
    end else begin
      rise_q <= '0;
      fall_q <= '0;
    end
  end

  assign level = level_q;
  assign rise = rise_q;
  assign fall = fall_q;
endmodule : input_sampler

/* verif/pin_source_model.sv */
`timescale 1ns/1ps
module pin_source_model #(
  parameter int HOLD = 16
) (
  // clock
  input wire logic clock,
  // pins toward the timer pair
  output logic [timer_pair_pkg::NUM_TIMERS-1:0] timer_input_pin,
  output logic [timer_pair_pkg::NUM_TIMERS-1:0] external_direction_pin,
  output logic capture_pin
);
  import timer_pair_pkg::*;

  initial begin
    timer_input_pin = '0;
    external_direction_pin = '0;
    capture_pin = 1'b0;
  end

  // kind 0 count or gate pin, 1 direction pin, 2 capture pin
  // called right after a rising edge; returns on a rising edge
  task automatic drive(input int kind, input int slot, input logic val);
    case (kind)
      0: timer_input_pin[slot] <= val;
      1: external_direction_pin[slot] <= val;
      default: capture_pin <= val;
    endcase
    // hold covers the slowest basic phase in use plus the sync delay
    repeat (HOLD) @(posedge clock);
  endtask : drive
endmodule : pin_source_model

/* verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import timer_pair_pkg::*;
  localparam int K = 512;
  localparam int LIMIT = 20000;
  logic clock;
  logic rst_n;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [15:0] reg_rdata;
  logic [NUM_TIMERS-1:0] timer_input_pin;
  logic [NUM_TIMERS-1:0] external_direction_pin;
  logic capture_pin;
  logic toggle_output_pin;
  logic capture_compare_clock;
  logic [NUM_EVENTS-1:0] event_pulse;
  logic irq;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  // last slot counts capture/compare clock pulses
  int ev_cnt [NUM_EVENTS+1] = '{default: 0};
  logic [15:0] v;
  logic [15:0] c;
  logic [1:0] bps [4] = '{2'h1, 2'h0, 2'h3, 2'h2};
  int fac [4] = '{4, 8, 16, 32};
  logic [15:0] pin_ctrl [9] = '{16'h0049, 16'h004a, 16'h004b, 16'h004c, 16'h0048,
                                16'h0071, 16'h0072, 16'h0073, 16'h0070};
  logic [15:0] pin_exp [9] = '{16'h1, 16'h1, 16'h2, 16'h0, 16'h0, 16'h2, 16'h2, 16'h4, 16'h0};
  logic [15:0] latch_exp [4] = '{16'h0, 16'h1, 16'h1, 16'h2};
  int cap_kind [3] = '{2, 0, 1};
  int cap_slot [3] = '{0, 1, 1};

  general_purpose_timer_pair #(.DATA_W(16)) dut (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .timer_input_pin(timer_input_pin), .external_direction_pin(external_direction_pin),
    .capture_pin(capture_pin), .toggle_output_pin(toggle_output_pin),
    .capture_compare_clock(capture_compare_clock), .event_pulse(event_pulse), .irq(irq));

  pin_source_model #(.HOLD(16)) src (
    .clock(clock), .timer_input_pin(timer_input_pin),
    .external_direction_pin(external_direction_pin), .capture_pin(capture_pin));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  always @(posedge clock) begin
    for (int i = 0; i < NUM_EVENTS; i++) begin
      if (event_pulse[i] === 1'b1) ev_cnt[i]++;
    end
    if (capture_compare_clock === 1'b1) ev_cnt[NUM_EVENTS]++;
    cycles++;
    if (cycles == LIMIT) begin
      num_errors++;
      $display("MISMATCH t=%0t run did not finish", $time);
      end_sim();
    end
  end

  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // bus tasks start and end just after a rising edge
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clock);
  endtask : rd

  task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] got;
    rd(a, got);
    chk(got, exp, $sformatf("read %h", a));
  endtask : rdc

  initial begin
    rst_n = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1 chk(16'(toggle_output_pin), 16'h0001, "output idle high");
    @(posedge clock);
    rdc(RA_CTRL0 + 5'h1, CTRL_RESET);
    rdc(5'h1f, 16'h0000);
    // readback bit is read-only, so a write to it alone reads back zero
    wr(RA_CTRL0, 16'h0200);
    rdc(RA_CTRL0, 16'h0000);
    wr(RA_CTRL0, 16'h0080);
    rdc(RA_CTRL0, 16'h0280);
    for (int p = 0; p < 2; p++) begin
      for (int u = 0; u < 2; u++) begin
        src.drive(1, 0, p[0]);
        wr(RA_CTRL0, 16'h0100 | 16'(u << 7));
        rdc(RA_CTRL0, 16'h0100 | 16'(u << 7) | 16'((p ^ u) << 9));
      end
    end
    src.drive(1, 0, 1'b0);
    // window of K cycles holds a whole number of count periods
    for (int i = 0; i < 4; i++) begin
      for (int s = 0; s < 3; s += 2) begin
        wr(RA_CTRL0 + 5'h1, 16'(bps[i]) << 12);
        wr(RA_CTRL0, 16'h0040 | 16'(s));
        rd(RA_CNT0, v);
        repeat (K - 2) @(posedge clock);
        rd(RA_CNT0, c);
        chk(c - v, 16'(K / (fac[i] << s)), "count rate");
      end
    end
    wr(RA_CTRL0, 16'h0000);
    wr(RA_CTRL0 + 5'h1, 16'h0000);
    for (int i = 0; i < 9; i++) begin
      wr(RA_CTRL0 + 5'h1, pin_ctrl[i]);
      wr(RA_CNT0 + 5'h1, 16'h0000);
      src.drive(0, 1, 1'b1);
      src.drive(0, 1, 1'b0);
      src.drive(1, 1, 1'b1);
      src.drive(1, 1, 1'b0);
      rdc(RA_CNT0 + 5'h1, pin_exp[i]);
    end
    wr(RA_CTRL0 + 5'h1, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      wr(RA_CNT0 + 5'h1, 16'h0100 + 16'(i));
      wr(RA_CNT0, 16'h0000);
      wr(RA_CTRL0, 16'h0028 | 16'(i));
      src.drive(0, 0, 1'b1);
      rdc(RA_CNT0, (i == 1 || i == 3) ? 16'h0100 + 16'(i) : 16'h0000);
      src.drive(0, 0, 1'b0);
      rdc(RA_CNT0, (i > 0 && i < 4) ? 16'h0100 + 16'(i) : 16'h0000);
    end
    chk(16'(ev_cnt[0]), 16'h0004, "capture pulses");
    wr(RA_CTRL0, 16'h0000);
    // two core wraps per pass: latch rises, then falls
    for (int i = 0; i < 4; i++) begin
      wr(RA_CTRL0 + 5'h1, 16'h0000);
      wr(RA_CTRL0 + 5'h2, 16'h004c + 16'(i));
      wr(RA_CNT0 + 5'h2, 16'h0000);
      wr(RA_CTRL0 + 5'h1, 16'h004b);
      repeat (2) begin
        wr(RA_CNT0 + 5'h1, 16'hffff);
        src.drive(0, 1, 1'b1);
        src.drive(0, 1, 1'b0);
      end
      rdc(RA_CNT0 + 5'h2, latch_exp[i]);
    end
    chk(16'(ev_cnt[1]), 16'h0008, "overflow pulses");
    wr(RA_CTRL0 + 5'h2, 16'h0000);
    wr(RA_CTRL0 + 5'h1, 16'h1000);
    wr(RA_CTRL0, 16'h0040);
    // period of 3 against a tick every 4 hits every tick phase once
    for (int j = 0; j < 4; j++) begin
      reg_addr <= RA_CNT0;
      reg_wdata <= 16'h5550 + 16'(j);
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 chk(reg_rdata, 16'h5550 + 16'(j), "cpu write");
      @(posedge clock);
    end
    // both aux reload on any latch edge: the second aux must win
    wr(RA_CTRL0, 16'h0027);
    wr(RA_CTRL0 + 5'h2, 16'h0027);
    wr(RA_CNT0, 16'h1234);
    wr(RA_CNT0 + 5'h2, 16'h5678);
    wr(RA_CTRL0 + 5'h1, 16'h004b);
    wr(RA_CNT0 + 5'h1, 16'hffff);
    src.drive(0, 1, 1'b1);
    rdc(RA_CNT0 + 5'h1, 16'h5678);
    src.drive(0, 1, 1'b0);
    wr(RA_CTRL0, 16'h0000);
    wr(RA_CTRL0 + 5'h1, 16'h0000);
    rd(RA_STATUS, v);
    wr(RA_CAPCTRL, 16'h0013);
    wr(RA_CAPREG, 16'h0010);
    wr(RA_CNT0 + 5'h4, 16'hffff);
    wr(RA_CNT0 + 5'h3, 16'h0000);
    wr(RA_CTRL0 + 5'h3, 16'h004d);
    wr(RA_CTRL0 + 5'h4, 16'h0849);
    #1 chk(16'(toggle_output_pin), 16'h0000, "latch shown");
    @(posedge clock);
    src.drive(0, 4, 1'b1);
    src.drive(0, 4, 1'b0);
    #1 chk(16'(toggle_output_pin), 16'h0001, "latch toggled");
    chk(16'(ev_cnt[NUM_EVENTS]), 16'h0001, "cc clock");
    chk(16'(irq), 16'h0000, "masked irq");
    @(posedge clock);
    rdc(RA_CNT0 + 5'h4, 16'h0010);
    rdc(RA_CNT0 + 5'h3, 16'h0001);
    wr(RA_MASK, 16'h0010);
    #1 chk(16'(irq), 16'h0001, "irq raised");
    @(posedge clock);
    rdc(RA_STATUS, 16'h0010);
    @(posedge clock);
    #1 chk(16'(irq), 16'h0000, "irq cleared");
    @(posedge clock);
    // gate open for two basic phases gives two counts
    wr(RA_CNT0 + 5'h4, 16'h0000);
    wr(RA_CTRL0 + 5'h4, 16'h0058);
    src.drive(0, 4, 1'b1);
    src.drive(0, 4, 1'b0);
    rdc(RA_CNT0 + 5'h4, 16'h0002);
    for (int s = 0; s < 3; s++) begin
      wr(RA_CNT0 + 5'h3, 16'h0a00 + 16'(s));
      wr(RA_CAPCTRL, 16'h0004 | 16'(s) | (s == 0 ? 16'h0020 : 16'h0000));
      src.drive(cap_kind[s], cap_slot[s], 1'b1);
      rdc(RA_CAPREG, 16'h0a00 + 16'(s));
      rdc(RA_CNT0 + 5'h3, s == 0 ? 16'h0000 : 16'h0a00 + 16'(s));
      src.drive(cap_kind[s], cap_slot[s], 1'b0);
    end
    chk(16'(ev_cnt[5]), 16'h0003, "capture events");
    end_sim();
  end
endmodule : tb_top
